// >>> src/rem_pkg.sv
// register map, field positions and codes of the read error machine check unit
// assumes one clock domain; software reaches registers over a plain port
// How it works
// - instruction read hard error waits for dispatch or operand access before trapping
// - data read error traps on prefetched operand use or error-tagged delivery
// - ownership read error traps only when its prefetched operand is accessed
// - hard error acknowledge or uncorrectable fill sets bus flag, posts soft interrupt
// - failed page-entry read sets cache status flag and aborts the miss
// - execution page-entry failure microtraps to fault routine which retries once
// - repeated failure on probe traps with lost-error bit; success restarts stream
// - write reference also sets write error flag, drops write, traps anytime
// - execution page trap in string instruction: frame holds next address as pc, current as saved pc
// - uncorrectable fill captures cache address and syndrome
// - repeated page-entry error while held sets second-error flag only
// - fill errors while status holds a report only set lost-error bit
package rem_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;
  localparam logic [3:0] OFS_BUS_STAT = 4'h0;
  localparam logic [3:0] OFS_FILL_ADDR = 4'h1;
  localparam logic [3:0] OFS_FILL_SYND = 4'h2;
  localparam logic [3:0] OFS_PC_STAT = 4'h3;
  localparam logic [3:0] OFS_IRQ_STAT = 4'h4;
  localparam logic [3:0] OFS_IRQ_MASK = 4'h5;
  localparam logic [3:0] OFS_FRAME_PC = 4'h6;
  localparam logic [3:0] OFS_SAVED_PC = 4'h7;
  localparam logic [3:0] OFS_PAGE_ADDR = 4'h8;
  // bus interface status fields
  localparam int BS_HERR = 0;
  localparam int BS_FILL = 1;
  localparam int BS_BSEO = 2;
  localparam int BS_FSEO = 3;
  // primary cache status fields
  localparam int PC_RDERR = 0;
  localparam int PC_WRERR = 1;
  localparam int PC_SEO = 2;
  // interrupt status fields
  localparam int IR_SOFT = 0;
  localparam int IR_MCHK = 1;
  localparam int IR_W = 2;
  // machine check causes
  typedef enum logic [2:0] {
    MC_NONE = 3'b000,
    MC_ISTREAM = 3'b001,
    MC_DSTREAM = 3'b010,
    MC_OWNER = 3'b011,
    MC_PAGE = 3'b100,
    MC_PAGE_WR = 3'b101
  } rem_cause_t;
endpackage

// >>> src/rem_pend.sv
// one pending read error held until consumed by its trigger or flushed
// assumes same-clock inputs
`timescale 1ns/100ps
module rem_pend (
  input wire logic clk, // clock
  input wire logic reset_n, // synchronous reset
  input wire logic setEv, // error arrives
  input wire logic useEv, // microcode consumes the data
  input wire logic flush, // pipeline flushed
  output logic trap // one-cycle trap request
);
  logic pend_ff;
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      pend_ff <= 1'b0;
    else if (setEv)
      pend_ff <= 1'b1;
    else if (useEv || flush)
      pend_ff <= 1'b0;
  end
  assign trap = pend_ff && useEv;
endmodule

// >>> src/rem_capture.sv
// holding register that takes din whenever load is high and keeps its value otherwise
// assumes same-clock inputs
`timescale 1ns/100ps
module rem_capture #(
  parameter int W = 32
) (
  input wire logic clk, // clock
  input wire logic reset_n, // synchronous reset
  input wire logic load, // take a new value
  input wire logic [W-1:0] din, // value to take
  output logic [W-1:0] dout // held value
);
  logic [W-1:0] val_ff;
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      val_ff <= '0;
    else if (load)
      val_ff <= din;
  end
  assign dout = val_ff;
endmodule

// >>> src/rem_top.sv
// read error reporting and machine check raising for the processor core
// assumes bus logic, microcode strobes and register port share clk
`timescale 1ns/100ps
module rem_top
  import rem_pkg::*;
#(
  parameter int AW = 32, // physical address width
  parameter int SW = 8 // syndrome width
) (
  input wire logic clk, // 10 MHz clock
  input wire logic reset_n, // synchronous reset
  input wire logic rdDone, // read reply strobe
  input wire logic cycleAckHardError, // reply is a hard error
  input wire logic fillUncorr, // reply fill uncorrectable
  input wire logic [AW-1:0] fillAddr, // cache address of reply
  input wire logic [SW-1:0] fillSyndrome, // ecc syndrome of reply
  input wire logic rdIstream, // reply for instruction read
  input wire logic rdOwner, // reply for ownership read
  input wire logic rdPageEntry, // reply for page-entry read
  input wire logic pageForExec, // page read on behalf of execution unit
  input wire logic pageRefWrite, // original reference is a write
  input wire logic [AW-1:0] origAddr, // original reference address
  input wire logic probeActive, // fault routine probe in progress
  input wire logic stringInstr, // interruptable string instruction
  input wire logic [AW-1:0] curPc, // interrupted instruction address
  input wire logic [AW-1:0] nextPc, // following instruction address
  input wire logic dispatchNew, // microcode dispatches new flow
  input wire logic operandAccess, // microcode accesses operand
  input wire logic tagDeliver, // error-tagged data into register file
  input wire logic flushPipe, // pipeline flush
  input wire logic [ADDR_W-1:0] regAddr, // register address
  input wire logic [DATA_W-1:0] regWdata, // write data
  input wire logic regWr, // write strobe
  input wire logic regRd, // read strobe
  output logic [DATA_W-1:0] regRdata, // read data
  output logic machineCheck, // machine check pulse
  output logic [2:0] mcCause, // cause of machine check
  output logic missAbort, // abort translation miss
  output logic faultTrap, // microtrap to fault routine
  output logic restartStream, // restart instruction stream
  output logic discardWrite, // drop original write
  output logic softIrq, // soft error interrupt request
  output logic irq // masked interrupt level
);
  logic [3:0] busStat_ff;
  logic [2:0] pcStat_ff;
  logic [IR_W-1:0] irqStat_ff, irqMask_ff;
  logic [AW-1:0] framePc_ff, savedPc_ff;
  logic [AW-1:0] fillAddrHeld, pageAddrHeld;
  logic [SW-1:0] syndHeld;
  logic [DATA_W-1:0] regRdata_ff;
  logic machineCheck_ff;
  logic missAbort_ff;
  logic faultTrap_ff;
  logic restart_ff;
  logic discard_ff;
  logic softIrq_ff;
  logic irq_ff;
  rem_cause_t cause_ff;
  logic wrBus;
  logic wrPcs;
  logic wrIrq;
  logic wrMask;
  logic herrEv;
  logic fillEv;
  logic pageEv;
  logic pageExec;
  logic trapI;
  logic trapD;
  logic trapO;
  logic busHeld;
  logic pageHeld;
  logic anyTrap;
  logic pageTrap;
  rem_cause_t nxt_cause;

  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [ADDR_W-1:0] o);
    hit = (a == o);
  endfunction

  assign wrBus = regWr && hit(regAddr, OFS_BUS_STAT);
  assign wrPcs = regWr && hit(regAddr, OFS_PC_STAT);
  assign wrIrq = regWr && hit(regAddr, OFS_IRQ_STAT);
  assign wrMask = regWr && hit(regAddr, OFS_IRQ_MASK);

  assign herrEv = rdDone && cycleAckHardError;
  assign fillEv = rdDone && fillUncorr && !cycleAckHardError;
  assign pageEv = rdDone && rdPageEntry && (cycleAckHardError || fillUncorr);
  assign pageExec = pageEv && pageForExec;
  assign busHeld = busStat_ff[BS_HERR] || busStat_ff[BS_FILL];
  assign pageHeld = pcStat_ff[PC_RDERR];

  // instruction stream waits for dispatch or operand access
  rem_pend u_pend_i (
    .clk(clk), .reset_n(reset_n),
    .setEv(rdDone && !rdPageEntry && rdIstream &&
           (cycleAckHardError || fillUncorr)),
    .useEv(dispatchNew || operandAccess), .flush(flushPipe),
    .trap(trapI)
  );
  // data stream traps on operand use or tagged delivery
  rem_pend u_pend_d (
    .clk(clk), .reset_n(reset_n),
    .setEv(rdDone && !rdPageEntry && !rdIstream && !rdOwner &&
           (cycleAckHardError || fillUncorr)),
    .useEv(operandAccess || tagDeliver), .flush(flushPipe),
    .trap(trapD)
  );
  // ownership read traps only on operand access
  rem_pend u_pend_o (
    .clk(clk), .reset_n(reset_n),
    .setEv(rdDone && !rdPageEntry && !rdIstream && rdOwner &&
           (cycleAckHardError || fillUncorr)),
    .useEv(operandAccess), .flush(flushPipe),
    .trap(trapO)
  );

  // page traps: probe repeat, or any write reference
  assign pageTrap = pageEv && ((pageForExec && probeActive) ||
                    pageRefWrite);
  assign anyTrap = trapI || trapD || trapO || pageTrap;

  always_comb
  begin
    nxt_cause = MC_NONE;
    if (pageTrap)
      nxt_cause = pageRefWrite ? MC_PAGE_WR : MC_PAGE;
    else if (trapI)
      nxt_cause = MC_ISTREAM;
    else if (trapD)
      nxt_cause = MC_DSTREAM;
    else if (trapO)
      nxt_cause = MC_OWNER;
  end

  // fill address and syndrome held until both hard error and fill flags cleared
  rem_capture #(.W(AW)) u_cap_addr (
    .clk(clk), .reset_n(reset_n),
    .load(fillEv && !busHeld),
    .din(fillAddr), .dout(fillAddrHeld)
  );
  rem_capture #(.W(SW)) u_cap_synd (
    .clk(clk), .reset_n(reset_n),
    .load(fillEv && !busHeld),
    .din(fillSyndrome), .dout(syndHeld)
  );
  rem_capture #(.W(AW)) u_cap_page (
    .clk(clk), .reset_n(reset_n),
    .load(pageEv && !pageHeld),
    .din(origAddr), .dout(pageAddrHeld)
  );

  // bus status: set wins over write-one-to-clear
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      busStat_ff <= 4'h0;
    else
    begin
      for (int i = 0; i < 4; i++)
        if (wrBus && regWdata[i])
          busStat_ff[i] <= 1'b0;
      if (herrEv && !busHeld)
        busStat_ff[BS_HERR] <= 1'b1;
      if (fillEv && !busHeld)
        busStat_ff[BS_FILL] <= 1'b1;
      if (herrEv && busHeld)
        busStat_ff[BS_BSEO] <= 1'b1;
      if (fillEv && busHeld)
        busStat_ff[BS_FSEO] <= 1'b1;
    end
  end

  // primary cache status for page-entry errors
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      pcStat_ff <= 3'h0;
    else
    begin
      for (int i = 0; i < 3; i++)
        if (wrPcs && regWdata[i])
          pcStat_ff[i] <= 1'b0;
      if (pageEv && !pageHeld)
      begin
        pcStat_ff[PC_RDERR] <= 1'b1;
        if (pageRefWrite)
          pcStat_ff[PC_WRERR] <= 1'b1;
      end
      if (pageEv && (pageHeld || (pageForExec && probeActive)))
        pcStat_ff[PC_SEO] <= 1'b1;
    end
  end

  // translation miss abort on any failing page-entry read
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      missAbort_ff <= 1'b0;
    else
      missAbort_ff <= pageEv;
  end

  // first execution failure goes to the fault routine for one retry
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      faultTrap_ff <= 1'b0;
    else
      faultTrap_ff <= pageExec && !probeActive && !pageRefWrite;
  end

  // clean probe lets microcode restart the stream
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      restart_ff <= 1'b0;
    else
      restart_ff <= rdDone && rdPageEntry && probeActive &&
                    !cycleAckHardError && !fillUncorr;
  end

  // a write whose translation failed is dropped
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      discard_ff <= 1'b0;
    else
      discard_ff <= pageEv && pageRefWrite;
  end

  // machine check pulse
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      machineCheck_ff <= 1'b0;
    else
      machineCheck_ff <= anyTrap;
  end

  // cause held from one machine check to the next
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      cause_ff <= MC_NONE;
    else if (anyTrap)
      cause_ff <= nxt_cause;
  end

  // frame program counters
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      framePc_ff <= '0;
      savedPc_ff <= '0;
    end
    else if (anyTrap)
    begin
      if (pageTrap && pageForExec && stringInstr)
      begin
        framePc_ff <= nextPc;
        savedPc_ff <= curPc;
      end
      else
      begin
        framePc_ff <= curPc;
        savedPc_ff <= '0;
      end
    end
  end

  // interrupt status: set wins over write-one-to-clear
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      irqStat_ff <= '0;
    else
    begin
      for (int i = 0; i < IR_W; i++)
        if (wrIrq && regWdata[i])
          irqStat_ff[i] <= 1'b0;
      if (herrEv || fillEv)
        irqStat_ff[IR_SOFT] <= 1'b1;
      if (anyTrap)
        irqStat_ff[IR_MCHK] <= 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
      irqMask_ff <= '0;
    else if (wrMask)
      irqMask_ff <= regWdata[IR_W-1:0];
  end

  // soft request raised without waiting for the status register
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      softIrq_ff <= 1'b0;
    else
      softIrq_ff <= irqStat_ff[IR_SOFT] || herrEv || fillEv;
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
      irq_ff <= 1'b0;
    else
      irq_ff <= |(irqStat_ff & irqMask_ff);
  end

  // register read port
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      regRdata_ff <= '0;
    else if (regRd)
    begin
      unique case (regAddr)
        OFS_BUS_STAT: regRdata_ff <= {28'h0000000, busStat_ff};
        OFS_FILL_ADDR: regRdata_ff <= DATA_W'(fillAddrHeld);
        OFS_FILL_SYND: regRdata_ff <= DATA_W'(syndHeld);
        OFS_PC_STAT: regRdata_ff <= {29'h0, pcStat_ff};
        OFS_IRQ_STAT: regRdata_ff <= DATA_W'(irqStat_ff);
        OFS_IRQ_MASK: regRdata_ff <= DATA_W'(irqMask_ff);
        OFS_FRAME_PC: regRdata_ff <= DATA_W'(framePc_ff);
        OFS_SAVED_PC: regRdata_ff <= DATA_W'(savedPc_ff);
        OFS_PAGE_ADDR: regRdata_ff <= DATA_W'(pageAddrHeld);
        default: regRdata_ff <= '0;
      endcase
    end
    else
      regRdata_ff <= '0;
  end

  assign regRdata = regRdata_ff;
  assign machineCheck = machineCheck_ff;
  assign mcCause = cause_ff;
  assign missAbort = missAbort_ff;
  assign faultTrap = faultTrap_ff;
  assign restartStream = restart_ff;
  assign discardWrite = discard_ff;
  assign softIrq = softIrq_ff;
  assign irq = irq_ff;
endmodule

// >>> sim/rem_top_chk.sv
// assertions on the ports of the read error machine check unit
// assumes one clock domain, bound into rem_top below
`timescale 1ns/100ps
module rem_top_chk
  import rem_pkg::*;
(
  input wire logic clk, // clock
  input wire logic reset_n, // synchronous reset
  input wire logic rdDone, // reply strobe
  input wire logic cycleAckHardError, // hard error reply
  input wire logic fillUncorr, // uncorrectable fill
  input wire logic rdIstream, // instruction read
  input wire logic rdOwner, // ownership read
  input wire logic rdPageEntry, // page-entry read
  input wire logic pageForExec, // execution reference
  input wire logic pageRefWrite, // write reference
  input wire logic probeActive, // probe running
  input wire logic dispatchNew, // new flow
  input wire logic operandAccess, // operand use
  input wire logic tagDeliver, // tagged delivery
  input wire logic flushPipe, // flush
  input wire logic machineCheck, // trap pulse
  input wire logic [2:0] mcCause, // trap cause
  input wire logic missAbort, // miss abort
  input wire logic faultTrap, // microtrap
  input wire logic discardWrite, // write dropped
  input wire logic softIrq // soft request
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  logic err;
  assign err = rdDone && (cycleAckHardError || fillUncorr);
  sequence s_page;
    err && rdPageEntry;
  endsequence
  sequence s_ierr;
    err && rdIstream && !rdPageEntry;
  endsequence
  sequence s_derr;
    err && !rdIstream && !rdOwner && !rdPageEntry;
  endsequence
  a_soft_post: assert property (err |=> softIrq)
    else $error("read error posted no soft request");
  a_page_abort: assert property (s_page |=> missAbort)
    else $error("page read error did not abort miss");
  a_exec_microtrap: assert property (s_page ##0
    (pageForExec && !probeActive && !pageRefWrite) |=> faultTrap)
    else $error("exec page error gave no microtrap");
  a_probe_repeat: assert property (s_page ##0
    (pageForExec && probeActive && !pageRefWrite)
    |=> machineCheck && mcCause == MC_PAGE)
    else $error("repeated probe error gave no page trap");
  a_write_drop: assert property (s_page ##0 pageRefWrite
    |=> discardWrite && machineCheck && mcCause == MC_PAGE_WR)
    else $error("page write error not dropped and trapped");
  a_no_early: assert property (err && !rdPageEntry
    && !dispatchNew && !operandAccess && !tagDeliver |=> !machineCheck)
    else $error("stream error trapped before use");
  a_dispatch_trap: assert property (s_ierr ##1
    (dispatchNew && !operandAccess && !tagDeliver && !flushPipe)
    |=> machineCheck && mcCause == MC_ISTREAM)
    else $error("istream error missed dispatch trap");
  a_tag_trap: assert property (s_derr ##1
    (tagDeliver && !operandAccess && !dispatchNew && !flushPipe)
    |=> machineCheck && mcCause == MC_DSTREAM)
    else $error("dstream error missed tag delivery trap");
endmodule
bind rem_top rem_top_chk chk_u (.clk, .reset_n, .rdDone, .cycleAckHardError,
  .fillUncorr, .rdIstream, .rdOwner, .rdPageEntry, .pageForExec,
  .pageRefWrite, .probeActive, .dispatchNew, .operandAccess, .tagDeliver,
  .flushPipe, .machineCheck, .mcCause, .missAbort, .faultTrap,
  .discardWrite, .softIrq);

// >>> sim/rem_bus_model.sv
// system bus logic model: answers one read after a chosen delay
// assumes one request outstanding; qualifiers churn outside replies
`timescale 1ns/100ps
module rem_bus_model (
  input wire logic clk, // clock
  input wire logic reset_n, // synchronous reset
  input wire logic go, // start a read
  input wire logic [2:0] goKind, // page, owner, istream
  input wire logic [1:0] goErr, // uncorrectable, hard error
  input wire logic [3:0] goDelay, // reply latency
  input wire logic [31:0] goAddr, // cache address
  output logic rdDone, // reply strobe
  output logic cycleAckHardError, // hard error reply
  output logic fillUncorr, // uncorrectable fill
  output logic [31:0] fillAddr, // reply address
  output logic [7:0] fillSyndrome, // reply syndrome
  output logic rdIstream, // instruction read
  output logic rdOwner, // ownership read
  output logic rdPageEntry, // page-entry read
  output logic busy // request outstanding
);
  logic [3:0] waitCnt;
  logic [2:0] kind;
  logic [1:0] err;
  logic [31:0] addr;
  always_ff @(posedge clk)
  begin
    rdDone <= 1'b0;
    fillAddr <= ~fillAddr;
    fillSyndrome <= ~fillSyndrome;
    {cycleAckHardError, fillUncorr} <= ~{cycleAckHardError, fillUncorr};
    {rdPageEntry, rdOwner, rdIstream} <= ~{rdPageEntry, rdOwner, rdIstream};
    if (!reset_n)
    begin
      busy <= 1'b0;
      {fillAddr, fillSyndrome, cycleAckHardError, fillUncorr} <= '0;
      {rdPageEntry, rdOwner, rdIstream} <= '0;
    end
    else if (go && !busy)
    begin
      busy <= 1'b1;
      {waitCnt, kind, err, addr} <= {goDelay, goKind, goErr, goAddr};
    end
    else if (busy && waitCnt != 4'h0)
      waitCnt <= waitCnt - 4'h1;
    else if (busy)
    begin
      busy <= 1'b0;
      rdDone <= 1'b1;
      {cycleAckHardError, fillUncorr} <= {err[0], err[1]};
      {rdPageEntry, rdOwner, rdIstream} <= kind;
      fillAddr <= addr;
      fillSyndrome <= addr[7:0] ^ 8'h5A;
    end
  end
endmodule

// >>> sim/tb_read_error_machine_check.sv
// self-checking bench of the read error machine check unit
// assumes rem_top, the bus model and the bound checker
`timescale 1ns/100ps
module tb_read_error_machine_check;
  import rem_pkg::*;
  logic clk, reset_n, rdDone, cycleAckHardError, fillUncorr, rdIstream;
  logic rdOwner, rdPageEntry, pageForExec, pageRefWrite, probeActive, go;
  logic stringInstr, dispatchNew, operandAccess, tagDeliver, flushPipe;
  logic regWr, regRd, machineCheck, missAbort, faultTrap, restartStream;
  logic discardWrite, softIrq, irq, busy;
  logic [31:0] fillAddr, origAddr, curPc, nextPc, regWdata, regRdata;
  logic [31:0] goAddr, a1, a2;
  logic [7:0] fillSyndrome;
  logic [3:0] regAddr, goDelay;
  logic [2:0] mcCause, goKind;
  logic [1:0] goErr;
  int n_mismatch = 0;
  int check_count = 0;
  int cyc = 0;
  rem_top dut_u (.clk, .reset_n, .rdDone, .cycleAckHardError, .fillUncorr,
    .fillAddr, .fillSyndrome, .rdIstream, .rdOwner, .rdPageEntry,
    .pageForExec, .pageRefWrite, .origAddr, .probeActive, .stringInstr,
    .curPc, .nextPc, .dispatchNew, .operandAccess, .tagDeliver, .flushPipe,
    .regAddr, .regWdata, .regWr, .regRd, .regRdata, .machineCheck, .mcCause,
    .missAbort, .faultTrap, .restartStream, .discardWrite, .softIrq, .irq);
  rem_bus_model bus_u (.clk, .reset_n, .go, .goKind, .goErr, .goDelay,
    .goAddr, .rdDone, .cycleAckHardError, .fillUncorr, .fillAddr,
    .fillSyndrome, .rdIstream, .rdOwner, .rdPageEntry, .busy);
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic print_verdict();
    if (n_mismatch == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_mismatch++;
      print_verdict();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    {regWr, regAddr, regWdata} <= {1'b1, a, d};
    @(posedge clk);
    regWr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rc(input logic [3:0] a, input logic [31:0] exp);
    {regRd, regAddr} <= {1'b1, a};
    @(posedge clk);
    regRd <= 1'b0;
    @(posedge clk);
    chk(regRdata, exp);
  endtask
  task automatic clr();
    wr(OFS_BUS_STAT, '1);
    wr(OFS_PC_STAT, '1);
    wr(OFS_IRQ_STAT, '1);
  endtask
  task automatic reply(input logic [2:0] k, input logic [1:0] e,
    input logic [31:0] a);
    int n;
    n = 0;
    {go, goKind, goErr, goAddr} <= {1'b1, k, e, a};
    goDelay <= 4'($urandom_range(0, 5));
    @(posedge clk);
    go <= 1'b0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (rdDone !== 1'b1 && n < 40);
    if (n >= 40)
      n_mismatch++;
  endtask
  // bits: flush, tag delivery, operand access, dispatch
  task automatic uc(input logic [3:0] v);
    {flushPipe, tagDeliver, operandAccess, dispatchNew} <= v;
    @(posedge clk);
    {flushPipe, tagDeliver, operandAccess, dispatchNew} <= 4'h0;
    @(posedge clk);
  endtask
  task automatic mc(input logic [3:0] v, input logic t, input rem_cause_t c);
    uc(v);
    chk(32'(machineCheck), 32'(t));
    if (t)
      chk(32'(mcCause), 32'(c));
  endtask
  initial
  begin
    void'($urandom(32'h6808));
    reset_n = 1'b0;
    {go, goKind, goErr, goDelay, goAddr, origAddr, curPc, nextPc} = '0;
    {probeActive, pageForExec, pageRefWrite, stringInstr} = '0;
    {dispatchNew, operandAccess, tagDeliver, flushPipe} = '0;
    {regWdata, regAddr, regWr, regRd} = '0;
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    rc(OFS_BUS_STAT, 32'h0);
    reply(3'b001, 2'b01, $urandom);
    rc(OFS_BUS_STAT, 32'(1 << BS_HERR));
    chk(32'({softIrq, irq}), 32'h2);
    mc(4'h0, 1'b0, MC_NONE);
    mc(4'h1, 1'b1, MC_ISTREAM);
    reply(3'b000, 2'b01, $urandom);
    mc(4'h4, 1'b1, MC_DSTREAM);
    reply(3'b010, 2'b01, $urandom);
    mc(4'h4, 1'b0, MC_NONE);
    mc(4'h2, 1'b1, MC_OWNER);
    clr();
    a1 = $urandom;
    a2 = $urandom;
    reply(3'b000, 2'b10, a1);
    rc(OFS_FILL_ADDR, a1);
    rc(OFS_FILL_SYND, {24'h0, a1[7:0] ^ 8'h5A});
    reply(3'b000, 2'b10, a2);
    rc(OFS_FILL_ADDR, a1);
    rc(OFS_BUS_STAT, 32'(1 << BS_FILL | 1 << BS_FSEO));
    wr(OFS_IRQ_MASK, 32'(1 << IR_SOFT));
    repeat (2) @(posedge clk);
    chk(32'(irq), 32'h1);
    clr();
    repeat (2) @(posedge clk);
    chk(32'(irq), 32'h0);
    reply(3'b000, 2'b10, a2);
    rc(OFS_FILL_ADDR, a2);
    mc(4'h8, 1'b0, MC_NONE);
    mc(4'h2, 1'b0, MC_NONE);
    rc(4'hF, 32'h0);
    clr();
    {pageForExec, stringInstr, origAddr} <= {2'b11, a1};
    {curPc, nextPc} <= {a2, a1 ^ a2};
    reply(3'b100, 2'b10, a1);
    @(posedge clk);
    chk(32'({missAbort, faultTrap}), 32'h3);
    rc(OFS_PC_STAT, 32'(1 << PC_RDERR));
    rc(OFS_PAGE_ADDR, a1);
    probeActive <= 1'b1;
    reply(3'b100, 2'b10, a2);
    @(posedge clk);
    chk(32'({machineCheck, mcCause}), 32'({1'b1, MC_PAGE}));
    rc(OFS_BUS_STAT, 32'(1 << BS_FILL | 1 << BS_FSEO));
    rc(OFS_PC_STAT, 32'(1 << PC_RDERR | 1 << PC_SEO));
    rc(OFS_FRAME_PC, a1 ^ a2);
    rc(OFS_SAVED_PC, a2);
    clr();
    reply(3'b100, 2'b00, a1);
    @(posedge clk);
    chk(32'(restartStream), 32'h1);
    {probeActive, pageRefWrite} <= 2'b01;
    reply(3'b100, 2'b01, a2);
    @(posedge clk);
    chk(32'({machineCheck, mcCause, discardWrite}),
        32'({1'b1, MC_PAGE_WR, 1'b1}));
    rc(OFS_PC_STAT, 32'(1 << PC_RDERR | 1 << PC_WRERR));
    rc(OFS_IRQ_STAT, 32'(1 << IR_SOFT | 1 << IR_MCHK));
    repeat (200)
    begin
      {probeActive, pageForExec, pageRefWrite, stringInstr} <= 4'($urandom);
      reply(3'($urandom), 2'($urandom), $urandom);
      uc(4'($urandom));
      if ($urandom_range(0, 3) == 0)
        clr();
    end
    print_verdict();
  end
endmodule
